//--- sdc_pkg.sv
// package: register map, fields, reset values and timing for the sdram config block
package sdc_pkg;
   localparam logic [7:0] OFF_MODE = 8'h00;
   localparam logic [7:0] OFF_REFRESH_INTERVAL = 8'h04;
   localparam logic [7:0] OFF_GEOMETRY_AND_TIMING = 8'h08;
   localparam logic [7:0] OFF_POWER_SAVING_CONFIG = 8'h10;
   localparam logic [7:0] OFF_IRQ_ENABLE_SET = 8'h14;
   localparam logic [7:0] OFF_IRQ_DISABLE_SET = 8'h18;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h1C;
   localparam logic [7:0] OFF_IRQ_STATUS = 8'h20;
   localparam logic [7:0] OFF_MEM_DEVICE = 8'h24;
   localparam logic [31:0] GEOMETRY_RESET = 32'h852372C0;
   localparam logic [31:0] POWER_RESET = 32'h00000000;
   localparam int COL_POS = 0;
   localparam int ROW_POS = 2;
   localparam int BANK_POS = 4;
   localparam int CAS_POS = 5;
   localparam int WIDTH_POS = 7;
   localparam int WR_POS = 8;
   localparam int RC_POS = 12;
   localparam int RP_POS = 16;
   localparam int RCD_POS = 20;
   localparam int RAS_POS = 24;
   localparam int XSR_POS = 28;
   localparam int LP_SEL_POS = 0;
   localparam int PARTIAL_ARRAY_REFRESH_POS = 4;
   localparam int TEMP_COMP_REFRESH_POS = 8;
   localparam int DS_POS = 10;
   localparam int TIMEOUT_POS = 12;
   localparam int REFRESH_ERR_BIT = 0;
   localparam logic [11:0] REFRESH_COUNT_RESET = 12'h000;
   localparam logic [1:0] LP_NONE = 2'h0;
   localparam logic [1:0] LP_SELF = 2'h1;
   localparam logic [1:0] LP_PDOWN = 2'h2;
   localparam logic [1:0] LP_DEEP = 2'h3;
   localparam logic [7:0] IDLE_64 = 8'h40;
   localparam logic [7:0] IDLE_128 = 8'h80;
   typedef enum logic [2:0] {
      SDC_IDLE = 3'b000,
      SDC_ACTIVE = 3'b001,
      SDC_LOWPOWER = 3'b011,
      SDC_EXIT = 3'b010,
      SDC_DEEP = 3'b110
   } sdc_state_t;
endpackage

//--- sdc_timer_if.sv
// interface: refresh timer load and pulse between the config core and its timer
`timescale 1ns/1ns
interface sdc_timer_if;
   logic armed;
   logic load;
   logic [11:0] count;
   logic pulse;
   modport core (output armed, output load, output count, input pulse);
   modport timer (input armed, input load, input count, output pulse);
endinterface

//--- sdc_refresh_timer.sv
// refresh interval down-timer
`timescale 1ns/1ns
module sdc_refresh_timer (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   sdc_timer_if.timer tif
);
   typedef struct packed {
      logic [11:0] cnt;
      logic pulse;
   } sdc_tmr_t;
   sdc_tmr_t st;
   sdc_tmr_t next_st;

   always_comb
   begin
      next_st = st;
      next_st.pulse = 1'b0;
      if (!tif.armed || tif.load)
      begin
         next_st.cnt = tif.count;
      end
      else if (st.cnt == 12'h000)
      begin
         next_st.cnt = tif.count;
         next_st.pulse = 1'b1;
      end
      else
      begin
         next_st.cnt = st.cnt - 12'h001;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st <= '0;
      end
      else if (ce)
      begin
         st <= next_st;
      end
   end

   // never armed until software writes the count
   assign tif.pulse = st.pulse & tif.armed;
endmodule

//--- sdc_cfg.sv
// sdram controller configuration, refresh timing and low-power policy
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
// Function
// - programmed 12-bit count reloads a down-timer; expiry pulses one refresh burst
// - no refresh at all until the refresh count is written
// - column field selects 8 to 11 column bits, reset 8
// - row field selects 11 to 13 row bits, code 11 reserved
// - bank bit selects two or four banks, reset two
// - cas field selects latency 1 to 3, code 00 reserved
// - width bit: 0 is 32-bit bus, 1 is 16-bit, reset 16
// - write recovery of 0 to 15 cycles, reset 2
// - refresh to activate wait of 0 to 15 cycles, reset 7
// - precharge to next command wait of 0 to 15, reset 3
// - activate to read or write wait of 0 to 15, reset 2
// - activate to precharge wait at least 0 to 15, reset 5
// - self-refresh exit wait from clock enable high, reset 8
// - low-power select 00 issues no low-power command
// - select 01 uses self-refresh, clock stopped, clock enable low
// - select 10 powers down after each access, clock enable low
// - select 11 issues deep power-down, low-power sdram only
// - partial array, temperature and drive parameters sent at initialization
// - idle timeout: immediate, 64 or 128 cycles, code 11 reserved
// - writing 1 to enable bit sets the refresh-error mask
// - writing 1 to disable bit clears the refresh-error mask
// - refresh-error status sets on error, clears on status read
// - refreshes continue while the memory sits in power-down
module sdc_cfg (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic access_req,
   input wire logic access_done,
   input wire logic refresh_error,
   output logic refresh_req,
   output logic mem_ready,
   output logic mem_clock_enable,
   output logic mem_clock_out_en,
   output logic self_refresh_cmd,
   output logic power_down_cmd,
   output logic deep_power_down_cmd,
   output logic [1:0] column_bits_sel,
   output logic [1:0] row_bits_sel,
   output logic bank_count_sel,
   output logic [1:0] cas_latency_sel,
   output logic bus_width_sel,
   output logic [3:0] write_recovery_delay,
   output logic [3:0] refresh_to_activate_delay,
   output logic [3:0] precharge_delay,
   output logic [3:0] row_to_column_delay,
   output logic [3:0] active_to_precharge_delay,
   output logic [3:0] selfref_exit_delay,
   output logic [2:0] partial_array_refresh,
   output logic [1:0] temp_comp_refresh,
   output logic [1:0] output_drive_strength,
   output logic [2:0] command_mode,
   output logic [1:0] mem_device_type,
   output logic irq
);
   typedef struct packed {
      logic aw_full;
      logic [7:0] aw_addr;
      logic w_full;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [2:0] mode;
      logic [11:0] refresh_count;
      logic refresh_armed;
      logic timer_load;
      logic [31:0] geometry;
      logic [31:0] power;
      logic irq_mask;
      logic err_status;
      logic [1:0] device;
      sdc_pkg::sdc_state_t fsm;
      logic [7:0] idle_cnt;
      logic [3:0] exit_cnt;
      logic irq;
   } sdc_cfg_t;
   sdc_cfg_t st;
   sdc_cfg_t next_st;
   sdc_timer_if tif ();

   logic wr_fire;
   logic rd_fire;
   logic [31:0] rd_word;
   logic [31:0] wmask;
   logic [7:0] idle_limit;
   logic [1:0] lp_sel;

   // byte enables expanded to a bit mask
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_lane
         assign wmask[gi*8 +: 8] = {8{st.w_strb[gi]}};
      end
   endgenerate

   assign wr_fire = st.aw_full && st.w_full && !st.bvalid;
   assign rd_fire = s_axi_arvalid && !st.rvalid;
   assign lp_sel = st.power[sdc_pkg::LP_SEL_POS +: 2];

   always_comb
   begin
      unique case (s_axi_araddr)
         sdc_pkg::OFF_MODE: rd_word = {29'h0, st.mode};
         sdc_pkg::OFF_REFRESH_INTERVAL: rd_word = {20'h0, st.refresh_count};
         sdc_pkg::OFF_GEOMETRY_AND_TIMING: rd_word = st.geometry;
         sdc_pkg::OFF_POWER_SAVING_CONFIG: rd_word = st.power;
         sdc_pkg::OFF_IRQ_MASK: rd_word = {31'h0, st.irq_mask};
         sdc_pkg::OFF_IRQ_STATUS: rd_word = {31'h0, st.err_status};
         sdc_pkg::OFF_MEM_DEVICE: rd_word = {30'h0, st.device};
         default: rd_word = 32'h00000000;
      endcase
   end

   always_comb
   begin
      unique case (st.power[sdc_pkg::TIMEOUT_POS +: 2])
         2'h1: idle_limit = sdc_pkg::IDLE_64;
         2'h2: idle_limit = sdc_pkg::IDLE_128;
         default: idle_limit = 8'h00;
      endcase
   end

   always_comb
   begin
      next_st = st;
      next_st.timer_load = 1'b0;
      if (s_axi_awvalid && !st.aw_full)
      begin
         next_st.aw_full = 1'b1;
         next_st.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st.w_full)
      begin
         next_st.w_full = 1'b1;
         next_st.w_data = s_axi_wdata;
         next_st.w_strb = s_axi_wstrb;
      end
      if (st.bvalid && s_axi_bready)
      begin
         next_st.bvalid = 1'b0;
      end
      if (st.rvalid && s_axi_rready)
      begin
         next_st.rvalid = 1'b0;
      end
      if (refresh_error)
      begin
         next_st.err_status = 1'b1;
      end
      if (wr_fire)
      begin
         next_st.aw_full = 1'b0;
         next_st.w_full = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = 2'h0;
         unique case (st.aw_addr)
            sdc_pkg::OFF_MODE:
            begin
               next_st.mode = (st.mode & ~wmask[2:0]) | (st.w_data[2:0] & wmask[2:0]);
            end
            sdc_pkg::OFF_REFRESH_INTERVAL:
            begin
               next_st.refresh_count = (st.refresh_count & ~wmask[11:0]) | (st.w_data[11:0] & wmask[11:0]);
               next_st.refresh_armed = st.refresh_armed | (|st.w_strb[1:0]);
               next_st.timer_load = 1'b1;
            end
            sdc_pkg::OFF_GEOMETRY_AND_TIMING:
            begin
               next_st.geometry = (st.geometry & ~wmask) | (st.w_data & wmask);
            end
            sdc_pkg::OFF_POWER_SAVING_CONFIG:
            begin
               next_st.power = ((st.power & ~wmask) | (st.w_data & wmask)) & 32'h00003F73;
            end
            sdc_pkg::OFF_IRQ_ENABLE_SET:
            begin
               if (st.w_strb[0] && st.w_data[sdc_pkg::REFRESH_ERR_BIT])
               begin
                  next_st.irq_mask = 1'b1;
               end
            end
            sdc_pkg::OFF_IRQ_DISABLE_SET:
            begin
               if (st.w_strb[0] && st.w_data[sdc_pkg::REFRESH_ERR_BIT])
               begin
                  next_st.irq_mask = 1'b0;
               end
            end
            sdc_pkg::OFF_MEM_DEVICE:
            begin
               next_st.device = (st.device & ~wmask[1:0]) | (st.w_data[1:0] & wmask[1:0]);
            end
            default:
            begin
               next_st.bresp = 2'h2;
            end
         endcase
      end
      if (rd_fire)
      begin
         next_st.rvalid = 1'b1;
         next_st.rdata = rd_word;
         next_st.rresp = 2'h0;
         unique case (s_axi_araddr)
            sdc_pkg::OFF_MODE, sdc_pkg::OFF_REFRESH_INTERVAL, sdc_pkg::OFF_GEOMETRY_AND_TIMING,
            sdc_pkg::OFF_POWER_SAVING_CONFIG, sdc_pkg::OFF_IRQ_MASK, sdc_pkg::OFF_MEM_DEVICE:
            begin
               next_st.rresp = 2'h0;
            end
            sdc_pkg::OFF_IRQ_STATUS:
            begin
               // a fresh error in the read cycle survives the clear
               next_st.err_status = refresh_error;
            end
            default:
            begin
               next_st.rresp = 2'h2;
            end
         endcase
      end
      // idle counter runs in master clock cycles
      if (access_req || st.fsm != sdc_pkg::SDC_IDLE)
      begin
         next_st.idle_cnt = 8'h00;
      end
      else if (st.idle_cnt != idle_limit)
      begin
         next_st.idle_cnt = st.idle_cnt + 8'h01;
      end
      unique case (st.fsm)
         sdc_pkg::SDC_IDLE:
         begin
            if (access_req)
            begin
               next_st.fsm = sdc_pkg::SDC_ACTIVE;
            end
            else if (lp_sel != sdc_pkg::LP_NONE && st.idle_cnt == idle_limit)
            begin
               next_st.fsm = (lp_sel == sdc_pkg::LP_DEEP) ? sdc_pkg::SDC_DEEP : sdc_pkg::SDC_LOWPOWER;
            end
         end
         sdc_pkg::SDC_ACTIVE:
         begin
            if (access_done)
            begin
               next_st.fsm = sdc_pkg::SDC_IDLE;
            end
         end
         sdc_pkg::SDC_LOWPOWER:
         begin
            if (access_req || lp_sel == sdc_pkg::LP_NONE)
            begin
               next_st.fsm = sdc_pkg::SDC_EXIT;
               next_st.exit_cnt = (lp_sel == sdc_pkg::LP_SELF) ? st.geometry[sdc_pkg::XSR_POS +: 4] : 4'h0;
            end
         end
         sdc_pkg::SDC_EXIT:
         begin
            if (st.exit_cnt == 4'h0)
            begin
               next_st.fsm = access_req ? sdc_pkg::SDC_ACTIVE : sdc_pkg::SDC_IDLE;
            end
            else
            begin
               next_st.exit_cnt = st.exit_cnt - 4'h1;
            end
         end
         sdc_pkg::SDC_DEEP:
         begin
            // data lost: only a new low-power select in the power-saving register leaves it
            if (lp_sel != sdc_pkg::LP_DEEP)
            begin
               next_st.fsm = sdc_pkg::SDC_IDLE;
            end
         end
         default:
         begin
            next_st.fsm = sdc_pkg::SDC_IDLE;
         end
      endcase
      next_st.irq = next_st.err_status & next_st.irq_mask;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st <= '0;
         st.refresh_count <= sdc_pkg::REFRESH_COUNT_RESET;
         st.geometry <= sdc_pkg::GEOMETRY_RESET;
         st.power <= sdc_pkg::POWER_RESET;
         st.fsm <= sdc_pkg::SDC_IDLE;
      end
      else if (ce)
      begin
         st <= next_st;
      end
   end

   assign tif.armed = st.refresh_armed;
   assign tif.load = st.timer_load;
   assign tif.count = st.refresh_count;

   sdc_refresh_timer u_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .tif(tif)
   );

   // refresh keeps running in power-down; self-refresh memory refreshes itself
   assign refresh_req = tif.pulse && !(st.fsm == sdc_pkg::SDC_LOWPOWER && lp_sel == sdc_pkg::LP_SELF)
                        && st.fsm != sdc_pkg::SDC_DEEP;

   assign s_axi_awready = !st.aw_full;
   assign s_axi_wready = !st.w_full;
   assign s_axi_bvalid = st.bvalid;
   assign s_axi_bresp = st.bresp;
   assign s_axi_arready = !st.rvalid;
   assign s_axi_rvalid = st.rvalid;
   assign s_axi_rresp = st.rresp;
   assign s_axi_rdata = st.rdata;

   assign mem_ready = st.fsm == sdc_pkg::SDC_ACTIVE;
   assign mem_clock_enable = !(st.fsm == sdc_pkg::SDC_LOWPOWER || st.fsm == sdc_pkg::SDC_DEEP);
   assign mem_clock_out_en = !((st.fsm == sdc_pkg::SDC_LOWPOWER && lp_sel == sdc_pkg::LP_SELF)
                               || st.fsm == sdc_pkg::SDC_DEEP);
   assign self_refresh_cmd = st.fsm == sdc_pkg::SDC_LOWPOWER && lp_sel == sdc_pkg::LP_SELF;
   assign power_down_cmd = st.fsm == sdc_pkg::SDC_LOWPOWER && lp_sel == sdc_pkg::LP_PDOWN;
   assign deep_power_down_cmd = st.fsm == sdc_pkg::SDC_DEEP;

   assign column_bits_sel = st.geometry[sdc_pkg::COL_POS +: 2];
   assign row_bits_sel = st.geometry[sdc_pkg::ROW_POS +: 2];
   assign bank_count_sel = st.geometry[sdc_pkg::BANK_POS];
   assign cas_latency_sel = st.geometry[sdc_pkg::CAS_POS +: 2];
   assign bus_width_sel = st.geometry[sdc_pkg::WIDTH_POS];
   assign write_recovery_delay = st.geometry[sdc_pkg::WR_POS +: 4];
   assign refresh_to_activate_delay = st.geometry[sdc_pkg::RC_POS +: 4];
   assign precharge_delay = st.geometry[sdc_pkg::RP_POS +: 4];
   assign row_to_column_delay = st.geometry[sdc_pkg::RCD_POS +: 4];
   assign active_to_precharge_delay = st.geometry[sdc_pkg::RAS_POS +: 4];
   assign selfref_exit_delay = st.geometry[sdc_pkg::XSR_POS +: 4];
   assign partial_array_refresh = st.power[sdc_pkg::PARTIAL_ARRAY_REFRESH_POS +: 3];
   assign temp_comp_refresh = st.power[sdc_pkg::TEMP_COMP_REFRESH_POS +: 2];
   assign output_drive_strength = st.power[sdc_pkg::DS_POS +: 2];
   assign command_mode = st.mode;
   assign mem_device_type = st.device;
   assign irq = st.irq;
endmodule

//--- sdc_cfg_props.sv
// checker: bus handshake, refresh start and low-power pin relations of the config block
`timescale 1ns/1ns
module sdc_cfg_props (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic refresh_req,
   input wire logic mem_ready,
   input wire logic mem_clock_enable,
   input wire logic mem_clock_out_en,
   input wire logic self_refresh_cmd,
   input wire logic power_down_cmd,
   input wire logic deep_power_down_cmd
);
   logic wrote;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // any write attempt may be the one that arms the timer, so this stays conservative
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         wrote <= 1'b0;
      else if (s_axi_awvalid)
         wrote <= 1'b1;
   end
   wr_resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped before taken");
   rd_resp_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read response changed before taken");
   rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address accepted while a response is pending");
   early_refresh_a: assert property (!wrote |-> !refresh_req)
      else $error("refresh before the interval was written");
   self_pins_a: assert property (self_refresh_cmd |-> !mem_clock_enable && !mem_clock_out_en)
      else $error("self-refresh with clock enable or clock running");
   pdown_pins_a: assert property (power_down_cmd |-> !mem_clock_enable && mem_clock_out_en)
      else $error("power-down pin levels wrong");
   deep_pins_a: assert property (deep_power_down_cmd |-> !mem_clock_enable && !mem_clock_out_en)
      else $error("deep power-down pin levels wrong");
   one_mode_a: assert property ($onehot0({self_refresh_cmd, power_down_cmd, deep_power_down_cmd}))
      else $error("more than one low-power command");
   self_quiet_a: assert property (self_refresh_cmd && $past(self_refresh_cmd) |-> !refresh_req)
      else $error("refresh issued during self-refresh");
   ready_awake_a: assert property (mem_ready |-> mem_clock_enable && mem_clock_out_en)
      else $error("access allowed while memory asleep");
   cover property (self_refresh_cmd ##[1:20] mem_ready);
   cover property (power_down_cmd && refresh_req);
   cover property (deep_power_down_cmd);
endmodule
bind sdc_cfg sdc_cfg_props i_sdc_cfg_props (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .refresh_req(refresh_req), .mem_ready(mem_ready), .mem_clock_enable(mem_clock_enable),
   .mem_clock_out_en(mem_clock_out_en), .self_refresh_cmd(self_refresh_cmd),
   .power_down_cmd(power_down_cmd), .deep_power_down_cmd(deep_power_down_cmd));

//--- sdc_mem_model.sv
// far-side memory: counts refresh pulses, measures their spacing, reports refresh errors on demand
`timescale 1ns/1ns
module sdc_mem_model (
   input wire logic aclk,
   input wire logic clr,
   input wire logic err_go,
   input wire logic refresh_req,
   output logic refresh_error,
   output logic [15:0] ref_cnt,
   output logic [15:0] gap
);
   logic [15:0] since;
   always_ff @(posedge aclk)
   begin
      refresh_error <= err_go;
      if (clr)
      begin
         ref_cnt <= 16'h0000;
         since <= 16'h0000;
      end
      else if (refresh_req)
      begin
         ref_cnt <= ref_cnt + 16'h0001;
         gap <= since + 16'h0001;
         since <= 16'h0000;
      end
      else
         since <= since + 16'h0001;
   end
endmodule

//--- testbench.sv
// testbench: register map, refresh timer, low-power policy and error interrupt of the config block
`timescale 1ns/1ns
module testbench;
   logic aclk, aresetn, ce, clr, err_go, access_req, access_done, refresh_error, refresh_req, irq, mem_ready;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, mem_clock_enable, mem_clock_out_en;
   logic self_refresh_cmd, power_down_cmd, deep_power_down_cmd, bus_width_sel, bank_count_sel;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rdat, pw;
   logic [3:0] s_axi_wstrb, write_recovery_delay, refresh_to_activate_delay, precharge_delay;
   logic [3:0] row_to_column_delay, active_to_precharge_delay, selfref_exit_delay;
   logic [1:0] s_axi_bresp, s_axi_rresp, br, rres, column_bits_sel, row_bits_sel, cas_latency_sel;
   logic [1:0] temp_comp_refresh, output_drive_strength;
   logic [2:0] partial_array_refresh;
   logic [15:0] ref_cnt, gap;
   logic [7:0] ra [5] = '{8'h04, 8'h08, 8'h10, 8'h1C, 8'h20};
   logic [31:0] rv [5] = '{32'h0, 32'h852372C0, 32'h0, 32'h0, 32'h0};
   logic [31:0] cv [3] = '{32'h0, 32'h25, 32'h9};
   int fail_count, n_tests, n;
   wire lp = self_refresh_cmd | power_down_cmd | deep_power_down_cmd;
   wire [31:0] geo = {selfref_exit_delay, active_to_precharge_delay, row_to_column_delay, precharge_delay,
      refresh_to_activate_delay, write_recovery_delay, bus_width_sel, cas_latency_sel, bank_count_sel,
      row_bits_sel, column_bits_sel};
   sdc_cfg i_sdc_cfg (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .access_req,
      .access_done, .refresh_error, .refresh_req, .mem_ready, .mem_clock_enable, .mem_clock_out_en,
      .self_refresh_cmd, .power_down_cmd, .deep_power_down_cmd, .column_bits_sel, .row_bits_sel,
      .bank_count_sel, .cas_latency_sel, .bus_width_sel, .write_recovery_delay, .refresh_to_activate_delay,
      .precharge_delay, .row_to_column_delay, .active_to_precharge_delay, .selfref_exit_delay,
      .partial_array_refresh, .temp_comp_refresh, .output_drive_strength, .command_mode(),
      .mem_device_type(), .irq);
   sdc_mem_model i_sdc_mem_model (.aclk, .clr, .err_go, .refresh_req, .refresh_error, .ref_cnt, .gap);
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic hang();
      fail_count++;
      $display("CHECK FAILED %0t wait ran out", $time);
      summarize();
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e)
      begin
         fail_count++;
         $display("CHECK FAILED %0t value %h expected %h", $time, g, e);
      end
   endtask
   task automatic chkb(input logic g, input logic e);
      n_tests++;
      if (g !== e)
      begin
         fail_count++;
         $display("CHECK FAILED %0t flag %b expected %b", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, tb;
      int i;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      tb = 1'b0;
      for (i = 0; i < 50 && !tb; i++)
      begin
         @(negedge aclk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tb = s_axi_bvalid;
         br = s_axi_bresp;
         @(posedge aclk);
         if (ta)
            s_axi_awvalid <= 1'b0;
         if (tw)
            s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      if (!tb)
         hang();
   endtask
   task automatic rd(input logic [7:0] a);
      logic ta, tr;
      int i;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      tr = 1'b0;
      for (i = 0; i < 50 && !tr; i++)
      begin
         @(negedge aclk);
         ta = s_axi_arvalid && s_axi_arready;
         tr = s_axi_rvalid;
         rdat = s_axi_rdata;
         rres = s_axi_rresp;
         @(posedge aclk);
         if (ta)
            s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      if (!tr)
         hang();
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk(rdat, e);
   endtask
   // counts edges until mem_ready (k=0) or a low-power command (k=1)
   task automatic waitf(input int k);
      n = 0;
      @(negedge aclk);
      while ((k == 1 ? lp : mem_ready) !== 1'b1)
      begin
         n++;
         if (n > 300)
            hang();
         @(negedge aclk);
      end
   endtask
   task automatic err_pulse();
      @(posedge aclk);
      err_go <= 1'b1;
      @(posedge aclk);
      err_go <= 1'b0;
      repeat (3) @(negedge aclk);
   endtask
   initial
   begin
      aclk = 1'b0;
      forever
         #2 aclk = ~aclk;
   end
   initial
   begin
      int t, s, p;
      {aresetn, err_go, access_req, access_done, s_axi_awvalid, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {ce, clr, s_axi_wstrb} = 6'h3F;
      {fail_count, n_tests} = '0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      clr <= 1'b0;
      foreach (ra[i])
         rdc(ra[i], rv[i]);
      chk(geo, 32'h852372C0);
      wr(8'h08, 32'hA15C36E5);
      chk(geo, 32'hA15C36E5);
      rdc(8'h08, 32'hA15C36E5);
      wr(8'h00, 32'h6);
      rdc(8'h00, 32'h6);
      wr(8'h24, 32'h1);
      rdc(8'h24, 32'h1);
      wr(8'h28, 32'h1);
      chk(32'(br), 32'h2);
      rdc(8'h28, 32'h0);
      chk(32'(rres), 32'h2);
      rd(8'h14);
      chk(32'(rres), 32'h2);
      repeat (200) @(negedge aclk);
      chk(32'(ref_cnt), 32'h0);
      foreach (cv[i])
      begin
         wr(8'h04, cv[i]);
         repeat (100) @(negedge aclk);
         chk(32'(gap), cv[i] + 32'h1);
      end
      p = 0;
      for (t = 0; t < 3; t++)
         for (s = 1; s < 4; s++)
         begin
            pw = 32'h650 | (32'(t) << 12) | 32'(s);
            // deep power-down is left only by a new select, so write before waking
            if (p == 3)
               wr(8'h10, pw);
            @(posedge aclk);
            access_req <= 1'b1;
            waitf(0);
            if (p == 1)
               chkb(n >= 10 && n <= 13, 1'b1);
            if (p == 2)
               chkb(n <= 3, 1'b1);
            if (p != 3)
               wr(8'h10, pw);
            @(posedge aclk);
            access_req <= 1'b0;
            access_done <= 1'b1;
            @(posedge aclk);
            access_done <= 1'b0;
            waitf(1);
            chkb(n >= t * 64 && n <= t * 64 + 3, 1'b1);
            chk({29'h0, deep_power_down_cmd, power_down_cmd, self_refresh_cmd}, 32'h1 << (s - 1));
            chkb(mem_clock_enable, 1'b0);
            chkb(mem_clock_out_en, s == 2);
            @(posedge aclk);
            clr <= 1'b1;
            @(posedge aclk);
            clr <= 1'b0;
            repeat (40) @(negedge aclk);
            chkb(ref_cnt != 16'h0, s == 2);
            p = s;
         end
      chk(32'({partial_array_refresh, temp_comp_refresh, output_drive_strength}), 32'h59);
      wr(8'h10, 32'hFFFFFFFC);
      rdc(8'h10, 32'h3F70);
      @(posedge aclk);
      access_req <= 1'b1;
      waitf(0);
      @(posedge aclk);
      access_req <= 1'b0;
      access_done <= 1'b1;
      @(posedge aclk);
      access_done <= 1'b0;
      repeat (200) @(negedge aclk);
      chkb(lp, 1'b0);
      err_pulse();
      chkb(irq, 1'b0);
      rdc(8'h20, 32'h1);
      rdc(8'h20, 32'h0);
      wr(8'h14, 32'h1);
      wr(8'h14, 32'h0);
      rdc(8'h1C, 32'h1);
      err_pulse();
      chkb(irq, 1'b1);
      rd(8'h20);
      repeat (2) @(negedge aclk);
      chkb(irq, 1'b0);
      wr(8'h18, 32'h0);
      rdc(8'h1C, 32'h1);
      wr(8'h18, 32'h1);
      rdc(8'h1C, 32'h0);
      err_pulse();
      chkb(irq, 1'b0);
      summarize();
   end
endmodule
